//--- common/qdc_defines.svh
// Register offsets, field positions, reset values and timing figures of the decoder.
`ifndef QDC_DEFINES_SVH
`define QDC_DEFINES_SVH
`define QDC_OFS_STAT 12'h100
`define QDC_OFS_STCLR 12'h104
`define QDC_OFS_INTSET 12'h304
`define QDC_OFS_INTDIS 12'h308
`define QDC_OFS_ENABLE 12'h500
`define QDC_OFS_INDICATOR_POLARITY 12'h504
`define QDC_OFS_SPER 12'h508
`define QDC_OFS_SAMPLE 12'h50c
`define QDC_OFS_RPER 12'h510
`define QDC_OFS_ACC 12'h514
`define QDC_OFS_DBL 12'h544
`define QDC_EV_SAMPLE 0
`define QDC_EV_REPORT 1
`define QDC_EV_ACCUMULATOR_OVERFLOW_EVENT 2
`define QDC_EV_DBL 3
`define QDC_EV_STOP 4
`define QDC_SPER_MAX 4'ha
`define QDC_BASE_US 128
`define QDC_CLK_MHZ 100
`define QDC_ACC_MAX 32'h000003ff
`define QDC_ACC_MIN 32'hfffffc00
`define QDC_RPER_RST 8'h0a
`define QDC_SMP_NEG 3'h7
`define QDC_SMP_ZERO 3'h0
`define QDC_SMP_POS 3'h1
`define QDC_SMP_DBL 3'h2
`endif

//--- common/qdc_pkg.sv
// Types shared by the decoder modules.
package qdc_pkg;
  typedef logic [4:0] qdc_ev_t;
  typedef logic [2:0] qdc_smp_t;
  typedef enum logic [1:0] {
    QDC_S_IDLE = 2'b01,
    QDC_S_RUN = 2'b10
  } qdc_sstate_t;
  typedef struct packed {
    qdc_sstate_t state;
    logic [23:0] cnt;
    logic [1:0] ab;
    logic valid;
    qdc_smp_t value;
  } qdc_samp_t;
  typedef struct packed {
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [31:0] rdata;
    qdc_ev_t inten;
    qdc_ev_t status;
    qdc_ev_t ev;
    logic enable;
    logic polarity;
    logic [3:0] sper;
    logic [7:0] rper;
    logic [7:0] rcnt;
    logic [31:0] acc;
    logic [31:0] dbl;
    qdc_smp_t sample;
  } qdc_core_t;
endpackage

//--- common/qdc_smp_if.sv
// Carrier between the register core and the sampler.
`timescale 1ns/1ns
interface qdc_smp_if;
  logic enable;
  logic [3:0] sper;
  logic valid;
  qdc_pkg::qdc_smp_t value;
  modport src (input enable, input sper, output valid, output value);
  modport snk (output enable, output sper, input valid, input value);
endinterface

//--- hw/qdc_sampler.sv
// Sample period timer and quadrature transition decoder.
`timescale 1ns/1ns
`include "qdc_defines.svh"
module qdc_sampler #(
  parameter int unsigned P_BASE_CYCLES = `QDC_BASE_US * `QDC_CLK_MHZ
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // Encoder pins
  input wire logic i_enc_a,
  input wire logic i_enc_b,
  // Core side
  qdc_smp_if.src smp
);
  import qdc_pkg::*;

  localparam qdc_samp_t SAMP_RST = '{state: QDC_S_IDLE, default: '0};

  qdc_samp_t q;
  qdc_samp_t d;
  logic [1:0] cur;

  // Codes above the top one run at the longest period rather than wrapping.
  function automatic logic [23:0] period_f(input logic [3:0] code);
    logic [3:0] c;
    c = (code > `QDC_SPER_MAX) ? `QDC_SPER_MAX : code;
    period_f = 24'(P_BASE_CYCLES) << c;
  endfunction

  function automatic qdc_smp_t decode_f(input logic [1:0] p, input logic [1:0] c);
    logic [1:0] fwd;
    fwd = {p[0], ~p[1]};
    if (p == c) begin
      decode_f = `QDC_SMP_ZERO;
    end else if ((p ^ c) == 2'h3) begin
      decode_f = `QDC_SMP_DBL;
    end else if (c == fwd) begin
      decode_f = `QDC_SMP_POS;
    end else begin
      decode_f = `QDC_SMP_NEG;
    end
  endfunction

  assign cur = {i_enc_a, i_enc_b};

  always_comb begin
    d = q;
    d.valid = 1'b0;
    case (q.state)
      QDC_S_IDLE: begin
        d.cnt = '0;
        if (smp.enable) begin
          d.ab = cur;
          d.state = QDC_S_RUN;
        end
      end
      QDC_S_RUN: begin
        if (!smp.enable) begin
          d.state = QDC_S_IDLE;
        end else if (q.cnt >= period_f(smp.sper) - 24'h1) begin
          d.cnt = '0;
          d.valid = 1'b1;
          d.value = decode_f(q.ab, cur);
          d.ab = cur;
        end else begin
          d.cnt = q.cnt + 24'h1;
        end
      end
      default: begin
        d = SAMP_RST;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      q <= SAMP_RST;
    end else begin
      q <= d;
    end
  end

  assign smp.valid = q.valid;
  assign smp.value = q.value;

  sample_period_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    smp.valid && $stable(smp.sper) && $past(q.state == QDC_S_RUN) |-> $past(q.cnt) == period_f(smp.sper) - 24'h1)
    else $error("sample taken off its period");
  sample_code_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    smp.valid |-> smp.value inside {`QDC_SMP_NEG, `QDC_SMP_ZERO, `QDC_SMP_POS, `QDC_SMP_DBL})
    else $error("sample value outside the legal codes");
endmodule // qdc_sampler

//--- hw/qdc_top.sv
// Quadrature decoder control: AHB-Lite registers, events, accumulation and pins.
// Contract
// - Interrupt disable register bit 0 is sample-ready; writing one disables that event.
// - Writing one to the report-ready disable bit clears only that enable.
// - Writing one to the overflow disable bit clears the overflow enable.
// - Writing one to the double-ready disable bit clears the double-ready enable.
// - Writing one to disable bit 4 clears the stopped enable.
// - Report-ready fires after the report interval only if the accumulator is nonzero.
// - Double-ready fires after the report interval only if the double count is nonzero.
// - Enable bit 0 switches the decoder on or off; it resets to zero.
// - Polarity bit 0 picks the LED active level: 0 low, 1 high.
// - Interval code 0 to 10 gives 128 us doubling to 131072 us per sample.
// - Writing one to an interrupt set bit enables that event.
// - A sample is two's complement with value 2 meaning a double transition.
// - A sample that would overflow the accumulator is dropped and flags overflow.
`timescale 1ns/1ns
`include "qdc_defines.svh"
module qdc_top #(
  parameter int unsigned P_BASE_CYCLES = `QDC_BASE_US * `QDC_CLK_MHZ
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // Interrupt
  output logic o_irq,
  // Encoder and LED pins
  input wire logic i_enc_a,
  input wire logic i_enc_b,
  output logic o_led,
  output logic o_led_oe,
  output logic o_enc_release
);
  import qdc_pkg::*;

  localparam qdc_core_t CORE_RST = '{rper: `QDC_RPER_RST, default: '0};

  qdc_core_t q;
  qdc_core_t d;
  qdc_smp_if smp ();

  logic accept;
  logic [11:0] aofs;
  logic clr_acc;
  logic clr_dbl;
  logic wr_set;
  logic wr_dis;
  qdc_ev_t clr;
  qdc_ev_t ev;
  logic [31:0] acc_base;
  logic [31:0] dbl_base;
  logic [31:0] sum;
  logic [31:0] sext;

  // ----------------------------------------------------------------
  // Sampler
  // ----------------------------------------------------------------
  qdc_sampler #(
    .P_BASE_CYCLES(P_BASE_CYCLES)
  ) u_sampler (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_enc_a(i_enc_a),
    .i_enc_b(i_enc_b),
    .smp(smp)
  );

  assign smp.enable = q.enable;
  assign smp.sper = q.sper;

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  function automatic logic [31:0] rd_f(input logic [11:0] a, input qdc_core_t s);
    case (a)
      `QDC_OFS_INTSET: begin
        rd_f = {27'h0, s.inten};
      end
      `QDC_OFS_INTDIS: begin
        rd_f = {27'h0, s.inten};
      end
      `QDC_OFS_STAT: begin
        rd_f = {27'h0, s.status};
      end
      `QDC_OFS_ENABLE: begin
        rd_f = {31'h0, s.enable};
      end
      `QDC_OFS_INDICATOR_POLARITY: begin
        rd_f = {31'h0, s.polarity};
      end
      `QDC_OFS_SPER: begin
        rd_f = {28'h0, s.sper};
      end
      `QDC_OFS_SAMPLE: begin
        rd_f = {{29{s.sample[2]}}, s.sample};
      end
      `QDC_OFS_RPER: begin
        rd_f = {24'h0, s.rper};
      end
      `QDC_OFS_ACC: begin
        rd_f = s.acc;
      end
      `QDC_OFS_DBL: begin
        rd_f = s.dbl;
      end
      default: begin
        rd_f = 32'h0;
      end
    endcase
  endfunction

  assign accept = i_hsel && i_htrans[1] && i_hready;
  assign aofs = i_haddr[11:0];
  // Reading a counter hands its value to software and restarts it in one step.
  assign clr_acc = accept && !i_hwrite && (aofs == `QDC_OFS_ACC);
  assign clr_dbl = accept && !i_hwrite && (aofs == `QDC_OFS_DBL);
  assign wr_set = q.wr_pend && (q.wr_addr == `QDC_OFS_INTSET);
  assign wr_dis = q.wr_pend && (q.wr_addr == `QDC_OFS_INTDIS);
  assign sext = {{29{smp.value[2]}}, smp.value};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    ev = '0;
    clr = '0;
    sum = 32'h0;
    d.wr_pend = accept && i_hwrite;
    if (accept) begin
      d.wr_addr = aofs;
      d.rdata = rd_f(aofs, q);
    end
    if (q.wr_pend) begin
      case (q.wr_addr)
        `QDC_OFS_INTSET: begin
          d.inten = q.inten | i_hwdata[4:0];
        end
        `QDC_OFS_INTDIS: begin
          // Zeros leave an enable alone.
          d.inten = q.inten & ~i_hwdata[4:0];
        end
        `QDC_OFS_STCLR: begin
          clr = i_hwdata[4:0];
        end
        `QDC_OFS_ENABLE: begin
          d.enable = i_hwdata[0];
          ev[`QDC_EV_STOP] = q.enable && !i_hwdata[0];
        end
        `QDC_OFS_INDICATOR_POLARITY: begin
          d.polarity = i_hwdata[0];
        end
        `QDC_OFS_SPER: begin
          d.sper = i_hwdata[3:0];
        end
        `QDC_OFS_RPER: begin
          d.rper = i_hwdata[7:0];
        end
        default: begin
          d.wr_addr = d.wr_addr;
        end
      endcase
    end
    acc_base = clr_acc ? 32'h0 : q.acc;
    dbl_base = clr_dbl ? 32'h0 : q.dbl;
    d.acc = acc_base;
    d.dbl = dbl_base;
    if (smp.valid) begin
      d.sample = smp.value;
      ev[`QDC_EV_SAMPLE] = 1'b1;
      if (smp.value == `QDC_SMP_DBL) begin
        d.dbl = dbl_base + 32'h1;
      end else begin
        sum = acc_base + sext;
        // Range is checked on the signed result so a wrap is never stored.
        if ($signed(sum) > $signed(`QDC_ACC_MAX) || $signed(sum) < $signed(`QDC_ACC_MIN)) begin
          ev[`QDC_EV_ACCUMULATOR_OVERFLOW_EVENT] = 1'b1;
        end else begin
          d.acc = sum;
        end
      end
      if (q.rcnt + 8'h1 >= q.rper) begin
        d.rcnt = 8'h0;
        ev[`QDC_EV_REPORT] = (d.acc != 32'h0);
        ev[`QDC_EV_DBL] = (d.dbl != 32'h0);
      end else begin
        d.rcnt = q.rcnt + 8'h1;
      end
    end
    d.ev = ev;
    // A new event beats a clear of the same bit in the same cycle.
    d.status = (q.status & ~clr) | ev;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      q <= CORE_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = q.rdata;
  assign o_irq = |(q.status & q.inten);
  // The LED is lit for the whole enabled time; its level follows polarity.
  assign o_led = q.enable ? q.polarity : 1'b0;
  assign o_led_oe = q.enable;
  assign o_enc_release = !q.enable;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);

  sequence s_rd_dis;
    accept && !i_hwrite && (aofs == `QDC_OFS_INTDIS);
  endsequence

  sequence s_wr_dis_addr;
    accept && i_hwrite && (aofs == `QDC_OFS_INTDIS);
  endsequence

  dis_sample_a: assert property (wr_dis && i_hwdata[0] |=> !q.inten[0])
    else $error("sample-ready enable not cleared");
  dis_report_a: assert property (wr_dis && i_hwdata[1] && !i_hwdata[0] |=>
    !q.inten[1] && (q.inten[0] == $past(q.inten[0])))
    else $error("report-ready disable disturbed another enable");
  dis_accumulator_overflow_event_a: assert property (wr_dis && i_hwdata[2] |=> !q.inten[2])
    else $error("overflow enable not cleared");
  dis_double_a: assert property (wr_dis && i_hwdata[3] |=> !q.inten[3])
    else $error("double-ready enable not cleared");
  dis_stop_a: assert property (s_wr_dis_addr ##1 i_hwdata[4] |=> !q.inten[4])
    else $error("stopped enable not cleared");
  report_gate_a: assert property (q.ev[1] |-> (q.acc != 32'h0) && (q.rcnt == 8'h0))
    else $error("report-ready with empty accumulator");
  double_gate_a: assert property (q.ev[3] |-> (q.dbl != 32'h0) && (q.rcnt == 8'h0))
    else $error("double-ready with zero double count");
  off_no_sample_a: assert property (!q.enable [*2] |-> !smp.valid)
    else $error("sample while decoder disabled");
  led_level_a: assert property (o_led_oe |-> (o_led == q.polarity))
    else $error("LED level ignores polarity");
  dis_read_a: assert property (s_rd_dis |=> o_hrdata == {27'h0, $past(q.inten)})
    else $error("disable register read mismatch");
  pin_release_a: assert property (!q.enable |-> !o_led_oe && o_enc_release)
    else $error("pins held while disabled");
  set_enable_a: assert property (wr_set && i_hwdata[0] |=> q.inten[0])
    else $error("interrupt set ignored");
  ovf_drop_a: assert property (q.ev[2] && !$past(clr_acc) |-> q.acc == $past(q.acc))
    else $error("overflowing sample was accumulated");

  // ----------------------------------------------------------------
  // Register writes, sample flow and pin levels
  // ----------------------------------------------------------------
  // Address-phase sequences let each write check line up with its data phase.
  sequence s_wr_set_addr;
    accept && i_hwrite && (aofs == `QDC_OFS_INTSET);
  endsequence

  sequence s_wr_en_addr;
    accept && i_hwrite && (aofs == `QDC_OFS_ENABLE);
  endsequence

  sequence s_wr_pol_addr;
    accept && i_hwrite && (aofs == `QDC_OFS_INDICATOR_POLARITY);
  endsequence

  sequence s_wr_sper_addr;
    accept && i_hwrite && (aofs == `QDC_OFS_SPER);
  endsequence

  sequence s_rd_acc;
    accept && !i_hwrite && (aofs == `QDC_OFS_ACC);
  endsequence

  sequence s_sample;
    smp.valid;
  endsequence

  sequence s_sample_dbl;
    s_sample ##0 (smp.value == `QDC_SMP_DBL);
  endsequence

  set_report_a: assert property (s_wr_set_addr ##1 i_hwdata[1] |=> q.inten[1])
    else $error("report-ready enable not set");
  set_keep_a: assert property (wr_set |=> (q.inten & $past(q.inten)) == $past(q.inten))
    else $error("interrupt set cleared an enable");
  dis_keep_a: assert property (wr_dis |=> (q.inten & ~$past(q.inten)) == 5'h0)
    else $error("interrupt disable set an enable");
  dis_zero_a: assert property (wr_dis && (i_hwdata[4:0] == 5'h0) |=> $stable(q.inten))
    else $error("zero write changed an enable");
  irq_masked_a: assert property ((q.inten == 5'h0) |-> !o_irq)
    else $error("interrupt with every event disabled");
  enable_write_a: assert property (s_wr_en_addr ##1 1'b1 |=> q.enable == $past(i_hwdata[0]))
    else $error("enable write lost");
  stop_event_a: assert property (s_wr_en_addr ##1 (q.enable && !i_hwdata[0]) |=>
    q.status[`QDC_EV_STOP])
    else $error("stopped event not raised");
  pol_write_a: assert property (s_wr_pol_addr ##1 1'b1 |=> q.polarity == $past(i_hwdata[0]))
    else $error("polarity write lost");
  led_low_a: assert property (o_led_oe && !q.polarity |-> !o_led)
    else $error("active-low LED driven high");
  led_idle_a: assert property (!o_led_oe |-> !o_led)
    else $error("LED level while pin released");
  sper_write_a: assert property (s_wr_sper_addr ##1 1'b1 |=> q.sper == $past(i_hwdata[3:0]))
    else $error("sample interval write lost");
  sample_reg_a: assert property (s_sample |=> q.sample == $past(smp.value))
    else $error("sample register missed a sample");
  sample_event_a: assert property (s_sample |=> q.status[`QDC_EV_SAMPLE])
    else $error("sample-ready event lost");
  dbl_count_a: assert property (s_sample_dbl ##0 !clr_dbl |=> q.dbl == $past(q.dbl) + 32'h1)
    else $error("double transition not counted");
  dbl_no_acc_a: assert property (s_sample_dbl ##0 !clr_acc |=> $stable(q.acc))
    else $error("double transition accumulated");
  acc_step_a: assert property (s_sample ##0 (smp.value != `QDC_SMP_DBL) && !clr_acc |=>
    (q.acc == $past(q.acc) + $past(sext)) || q.ev[`QDC_EV_ACCUMULATOR_OVERFLOW_EVENT])
    else $error("sample neither accumulated nor flagged");
  acc_range_a: assert property ($signed(q.acc) <= $signed(`QDC_ACC_MAX) &&
    $signed(q.acc) >= $signed(`QDC_ACC_MIN))
    else $error("accumulator outside its range");
  acc_clear_a: assert property (s_rd_acc ##0 !smp.valid |=> q.acc == 32'h0)
    else $error("accumulator not cleared by its read");
  report_src_a: assert property (q.ev[`QDC_EV_REPORT] |-> $past(smp.valid))
    else $error("report-ready without a sample");
  double_src_a: assert property (q.ev[`QDC_EV_DBL] |-> $past(smp.valid))
    else $error("double-ready without a sample");
  rdata_hold_a: assert property (!accept |=> $stable(o_hrdata))
    else $error("read data moved outside an access");
endmodule // qdc_top

//--- sim/qdc_enc_model.sv
// Quadrature encoder model that steps its two phases at a fixed pace.
`timescale 1ns/1ns
module qdc_enc_model (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // Motion control: 0 still, 1 forward, 2 reverse, 3 double step
  input wire logic [1:0] i_mode,
  input wire logic [15:0] i_period,
  // Encoder phases
  output logic o_enc_a,
  output logic o_enc_b
);
  logic [1:0] pos_q;
  logic [15:0] cnt_q;

  // Gray coding keeps a single phase change per forward or reverse step.
  assign o_enc_a = pos_q[1];
  assign o_enc_b = pos_q[1] ^ pos_q[0];

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      pos_q <= 2'h0;
      cnt_q <= 16'h0;
    end else if (i_mode != 2'h0 && cnt_q + 16'h1 >= i_period) begin
      cnt_q <= 16'h0;
      case (i_mode)
        2'h1: pos_q <= pos_q + 2'h1;
        2'h2: pos_q <= pos_q - 2'h1;
        default: pos_q <= pos_q + 2'h2;
      endcase
    end else begin
      cnt_q <= cnt_q + 16'h1;
    end
  end
endmodule // qdc_enc_model

//--- sim/test_quadrature_decoder_control.sv
// Self-checking bench for the decoder control block.
`timescale 1ns/1ns
module test_quadrature_decoder_control;
  // Short base period keeps the longest sample interval near four thousand cycles.
  localparam int unsigned PB = 4;
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_hsel = 1'b0;
  logic [31:0] i_haddr = 32'h0;
  logic [1:0] i_htrans = 2'h0;
  logic i_hwrite = 1'b0;
  logic [31:0] i_hwdata = 32'h0;
  logic o_hreadyout, o_hresp, o_irq, o_led, o_led_oe, o_enc_release, enc_a, enc_b;
  logic [31:0] o_hrdata, rd_val, d;
  logic [63:0] ev;
  logic [1:0] mode = 2'h0;
  logic [15:0] per = 16'(PB);
  logic [63:0] exp_q[$];
  event rd_ev;
  int n_fail = 0;
  int n_checks = 0;
  int n;

  always #5 i_ref_clk = ~i_ref_clk;

  qdc_top #(.P_BASE_CYCLES(PB)) u_qdc_top (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata),
    .i_hready(o_hreadyout), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata), .o_irq(o_irq),
    .i_enc_a(enc_a), .i_enc_b(enc_b), .o_led(o_led), .o_led_oe(o_led_oe), .o_enc_release(o_enc_release));
  qdc_enc_model u_qdc_enc_model (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_mode(mode), .i_period(per),
    .o_enc_a(enc_a), .o_enc_b(enc_b));

  // ----------------------------------------
  // Bus tasks and comparisons
  // ----------------------------------------
  task automatic fail(input string msg);
    n_fail++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask

  // Compares at once: the value is taken when the task is called, so callers let outputs settle first.
  task automatic cmp_bit(input logic got, input logic exp, input string msg);
    n_checks++;
    if (got !== exp) fail(msg);
  endtask

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [31:0] e,
      input logic [31:0] m);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr <= {20'h0, a};
    i_hwrite <= wr;
    @(posedge i_ref_clk);
    while (o_hreadyout !== 1'b1) @(posedge i_ref_clk);
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    if (!wr) exp_q.push_back({m, e});
    @(posedge i_ref_clk);
    while (o_hreadyout !== 1'b1) @(posedge i_ref_clk);
    cmp_bit(o_hresp, 1'b0, "error response");
    if (!wr) begin
      rd_val = o_hrdata;
      ->rd_ev;
    end
  endtask

  // The extra edge lets a written register reach the outputs before anyone looks at them.
  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    bus(1'b1, a, wd, 32'h0, 32'h0);
    @(posedge i_ref_clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
    bus(1'b0, a, 32'h0, e, m);
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge i_ref_clk);
  endtask

  always begin
    @(rd_ev);
    n_checks++;
    if (exp_q.size() == 0) begin
      fail("unexpected read");
    end else begin
      ev = exp_q.pop_front();
      if (((rd_val ^ ev[31:0]) & ev[63:32]) !== 32'h0) fail("read data");
    end
  end

  task automatic test_done();
    if (exp_q.size() != 0) fail("reads left unchecked");
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #(60000 * 10);
    fail("timeout");
    test_done();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(22));
    repeat (10) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    @(posedge i_ref_clk);
    rd(12'h308, 32'h0);
    rd(12'h500, 32'h0);
    rd(12'h504, 32'h0);
    rd(12'h508, 32'h0);
    wr(12'h600, 32'hffffffff);
    rd(12'h600, 32'h0);
    cmp_bit(o_enc_release, 1'b1, "pins held after reset");
    wr(12'h304, 32'h1f);
    rd(12'h308, 32'h1f);
    wr(12'h308, 32'h0);
    rd(12'h308, 32'h1f);
    for (int i = 0; i < 5; i++) begin
      wr(12'h308, 32'h1 << i);
      rd(12'h308, (32'h3e << i) & 32'h1f);
    end
    repeat (4) begin
      d = $urandom;
      wr(12'h504, d);
      rd(12'h504, {31'h0, d[0]});
      d[3:0] = 4'($urandom % 11);
      wr(12'h508, d);
      rd(12'h508, {28'h0, d[3:0]});
    end
    wr(12'h504, 32'h1);
    wr(12'h500, 32'h1);
    cmp_bit(o_led, 1'b1, "led level high");
    cmp_bit(o_led_oe, 1'b1, "led not driven");
    cmp_bit(o_enc_release, 1'b0, "pins still free");
    wr(12'h504, 32'h0);
    cmp_bit(o_led, 1'b0, "led level low");
    wr(12'h500, 32'h0);
    cmp_bit(o_enc_release, 1'b1, "pins not freed");
    wr(12'h304, 32'h1);
    // The last pass writes a code above the top one, which must run at the longest period.
    for (int c = 0; c <= 11; c++) begin
      wr(12'h104, 32'h1f);
      wr(12'h508, (c > 10) ? 32'hf : 32'(c));
      wr(12'h500, 32'h1);
      n = 0;
      while (o_irq !== 1'b1 && n < 20000) begin
        @(posedge i_ref_clk);
        n++;
      end
      // Sampling starts one edge after enable lands; status shows the first sample one edge after it.
      cmp_bit(n == (PB << ((c > 10) ? 10 : c)) + 2, 1'b1, "sample period");
      wr(12'h500, 32'h0);
    end
    wr(12'h308, 32'h1);
    cmp_bit(o_irq, 1'b0, "masked event interrupts");
    wr(12'h304, 32'h1);
    cmp_bit(o_irq, 1'b1, "enabled event silent");
    wr(12'h510, 32'h2);
    rd(12'h514, 32'h0, 32'h0);
    rd(12'h544, 32'h0, 32'h0);
    wr(12'h104, 32'h1f);
    wr(12'h508, 32'h0);
    wr(12'h500, 32'h1);
    idle(40);
    rd(12'h100, 32'h0, 32'ha);
    mode <= 2'h2;
    idle(40);
    rd(12'h50c, 32'hffffffff);
    rd(12'h100, 32'h2, 32'ha);
    mode <= 2'h3;
    idle(40);
    rd(12'h50c, 32'h2);
    rd(12'h100, 32'h8, 32'h8);
    mode <= 2'h1;
    rd(12'h514, 32'h0, 32'h0);
    idle(4200);
    rd(12'h514, 32'h3ff);
    rd(12'h100, 32'h4, 32'h4);
    // The watcher takes the last read in the same time step; give it room before the verdict.
    idle(2);
    test_done();
  end
endmodule // test_quadrature_decoder_control
